/* File: tpfmt_analyzer.sv */
// Capture model of the external trace port analyzer
`timescale 1ns/1ps
`default_nettype none
`include "tpfmt_regs.svh"
module tpfmt_analyzer #(
  parameter logic [31:0] MARKER = 32'h0bad0bad
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clear,
  input wire logic [31:0] port_data,
  input wire logic port_valid,
  input wire logic port_sync,
  output logic [15:0] n_pat,
  output logic [15:0] n_sync,
  output logic [15:0] max_run,
  output logic first_sync,
  output logic pat_then_sync,
  output logic saw_marker
);
  logic [15:0] run;
  logic seen;
  logic last_pat;
  // ****************************************************
  // Capture
  // ****************************************************
  // Only valid words count; idle cycles carry no frame
  always_ff @(posedge clock) begin
    if (!reset_n || clear) begin
      n_pat <= 16'h0;
      n_sync <= 16'h0;
      max_run <= 16'h0;
      run <= 16'h0;
      seen <= 1'b0;
      last_pat <= 1'b0;
      first_sync <= 1'b0;
      pat_then_sync <= 1'b0;
      saw_marker <= 1'b0;
    end else if (port_valid) begin
      seen <= 1'b1;
      if (!seen) begin
        first_sync <= port_sync;
      end
      if (port_sync && port_data == `TPFMT_SYNC_WORD) begin
        n_sync <= n_sync + 16'h1;
        run <= 16'h0;
        pat_then_sync <= pat_then_sync | last_pat;
      end else begin
        run <= run + 16'h1;
        max_run <= (run + 16'h1 > max_run) ? run + 16'h1 : max_run;
      end
      last_pat <= !port_sync && port_data == `TPFMT_PATTERN_WORD;
      n_pat <= n_pat + ((!port_sync && port_data == `TPFMT_PATTERN_WORD) ? 16'h1 : 16'h0);
      saw_marker <= saw_marker | (port_data == MARKER);
    end
  end
endmodule : tpfmt_analyzer
`default_nettype wire

/* File: tpfmt_pkg.sv */
// Types of the trace port formatter
`default_nettype none
package tpfmt_pkg;
  typedef enum logic [3:0] {
    TPFMT_IDLE = 4'h1,
    TPFMT_PATTERN = 4'h2,
    TPFMT_SYNC = 4'h4,
    TPFMT_FORMAT = 4'h8
  } tpfmt_state_e;
endpackage : tpfmt_pkg
`default_nettype wire

/* File: tpfmt_regs.svh */
// Register offsets, fields and constants of the trace port formatter
`ifndef TPFMT_REGS_SVH
`define TPFMT_REGS_SVH
// ****************************************************
// Register byte offsets
// ****************************************************
`define TPFMT_OFS_FLUSH_CONTROL 12'h000
`define TPFMT_OFS_FLUSH_STATUS 12'h004
`define TPFMT_OFS_SYNC_COUNTER 12'h008
`define TPFMT_OFS_PATTERN_MODE 12'h00c
`define TPFMT_OFS_PATTERN_COUNT 12'h010
`define TPFMT_OFS_IRQ_STATUS 12'h014
`define TPFMT_OFS_IRQ_MASK 12'h018
`define TPFMT_OFS_IDENT 12'h01c
// ****************************************************
// Fields
// ****************************************************
`define TPFMT_FC_FORMATTER_ENABLE 0
`define TPFMT_FC_CONTINUOUS 1
`define TPFMT_FC_MANUAL_FLUSH 6
`define TPFMT_FC_STOP_ON_FLUSH 12
`define TPFMT_FS_STOPPED 1
`define TPFMT_PM_PATTERN_ENABLE 0
`define TPFMT_PM_TIMED_ENABLE 1
`define TPFMT_IRQ_PATTERN_DONE 0
`define TPFMT_IRQ_STOPPED 1
`define TPFMT_IRQ_SYNC 2
// ****************************************************
// Values
// ****************************************************
`define TPFMT_SYNC_WORD 32'h7fffffff
`define TPFMT_PATTERN_WORD 32'haaaa5555
`define TPFMT_SYNC_DEFAULT 12'h040
`define TPFMT_IDENT_VALUE 32'h00c0ffee
`define TPFMT_FRAME_LAST 2'h3
`define TPFMT_RESP_OKAY 2'h0
`define TPFMT_RESP_SLVERR 2'h2
`endif

/* File: tpfmt_unit.sv */
// Trace port formatter with pattern generator and AXI4-Lite registers
//
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "tpfmt_regs.svh"
module tpfmt_unit (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] trace_data,
  input wire logic trace_valid,
  output logic trace_ready,
  output logic [31:0] port_data,
  output logic port_valid,
  output logic port_sync,
  output logic irq
);
  typedef struct packed {
    logic aw_held;
    logic [11:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic fmt_enable;
    logic continuous;
    logic stop_on_flush;
    logic manual_flush;
    logic stopped;
    logic pattern_enable;
    logic timed_enable;
    logic [11:0] sync_period;
    logic [15:0] pattern_count;
    logic [15:0] pattern_left;
    logic [11:0] frame_count;
    logic [1:0] word_in_frame;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    tpfmt_pkg::tpfmt_state_e state;
    logic [31:0] port_data;
    logic port_valid;
    logic port_sync;
    logic trace_ready;
    logic irq;
  } tpfmt_state_s;

  tpfmt_state_s st;
  tpfmt_state_s next_st;
  logic wr_fire;
  logic rd_fire;
  logic [2:0] events;

  // ****************************************************
  // Next state
  // ****************************************************
  always_comb begin
    next_st = st;
    events = 3'h0;
    wr_fire = st.aw_held && st.w_held && !st.bvalid;
    rd_fire = s_axi_arvalid && !st.rvalid;
    // Address and data accepted in either order
    if (s_axi_awvalid && !st.aw_held) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.w_held) begin
      next_st.w_held = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (wr_fire) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = `TPFMT_RESP_OKAY;
      // Byte lane 0 carries the enable, continuous and manual flush bits; stop-on-flush sits in byte lane 1
      if (st.aw_addr == `TPFMT_OFS_FLUSH_CONTROL) begin
        if (st.w_strb[0]) begin
          next_st.fmt_enable = st.w_data[`TPFMT_FC_FORMATTER_ENABLE];
          next_st.continuous = st.w_data[`TPFMT_FC_CONTINUOUS];
          next_st.manual_flush = st.w_data[`TPFMT_FC_MANUAL_FLUSH];
        end
        if (st.w_strb[1]) begin
          next_st.stop_on_flush = st.w_data[`TPFMT_FC_STOP_ON_FLUSH];
        end
        if (st.w_strb[0] && st.w_data[`TPFMT_FC_FORMATTER_ENABLE] && st.stopped) begin
          next_st.stopped = 1'b0;
          next_st.state = tpfmt_pkg::TPFMT_SYNC;
        end
      end else if (st.aw_addr == `TPFMT_OFS_SYNC_COUNTER) begin
        next_st.sync_period = st.w_data[11:0];
      end else if (st.aw_addr == `TPFMT_OFS_PATTERN_MODE) begin
        next_st.pattern_enable = st.w_data[`TPFMT_PM_PATTERN_ENABLE];
        next_st.timed_enable = st.w_data[`TPFMT_PM_TIMED_ENABLE];
        if (st.w_data[`TPFMT_PM_PATTERN_ENABLE]) begin
          next_st.pattern_left = st.pattern_count;
          next_st.state = tpfmt_pkg::TPFMT_PATTERN;
        end
      end else if (st.aw_addr == `TPFMT_OFS_PATTERN_COUNT) begin
        next_st.pattern_count = st.w_data[15:0];
      end else if (st.aw_addr == `TPFMT_OFS_IRQ_STATUS) begin
        next_st.irq_status = st.irq_status & ~st.w_data[2:0];
      end else if (st.aw_addr == `TPFMT_OFS_IRQ_MASK) begin
        next_st.irq_mask = st.w_data[2:0];
      end else if (st.aw_addr != `TPFMT_OFS_FLUSH_STATUS && st.aw_addr != `TPFMT_OFS_IDENT) begin
        next_st.bresp = `TPFMT_RESP_SLVERR;
      end
    end
    if (rd_fire) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = `TPFMT_RESP_OKAY;
      next_st.rdata = 32'h0;
      if (s_axi_araddr == `TPFMT_OFS_FLUSH_CONTROL) begin
        next_st.rdata[`TPFMT_FC_FORMATTER_ENABLE] = st.fmt_enable;
        next_st.rdata[`TPFMT_FC_CONTINUOUS] = st.continuous;
        next_st.rdata[`TPFMT_FC_MANUAL_FLUSH] = st.manual_flush;
        next_st.rdata[`TPFMT_FC_STOP_ON_FLUSH] = st.stop_on_flush;
      end else if (s_axi_araddr == `TPFMT_OFS_FLUSH_STATUS) begin
        next_st.rdata[`TPFMT_FS_STOPPED] = st.stopped;
      end else if (s_axi_araddr == `TPFMT_OFS_SYNC_COUNTER) begin
        next_st.rdata[11:0] = st.sync_period;
      end else if (s_axi_araddr == `TPFMT_OFS_PATTERN_MODE) begin
        next_st.rdata[`TPFMT_PM_PATTERN_ENABLE] = st.pattern_enable;
        next_st.rdata[`TPFMT_PM_TIMED_ENABLE] = st.timed_enable;
      end else if (s_axi_araddr == `TPFMT_OFS_PATTERN_COUNT) begin
        next_st.rdata[15:0] = st.pattern_count;
      end else if (s_axi_araddr == `TPFMT_OFS_IRQ_STATUS) begin
        next_st.rdata[2:0] = st.irq_status;
      end else if (s_axi_araddr == `TPFMT_OFS_IRQ_MASK) begin
        next_st.rdata[2:0] = st.irq_mask;
      end else if (s_axi_araddr == `TPFMT_OFS_IDENT) begin
        // Arbitrary identity value
        next_st.rdata = `TPFMT_IDENT_VALUE;
      end else begin
        next_st.rresp = `TPFMT_RESP_SLVERR;
      end
    end

    // ****************************************************
    // Trace stream
    // ****************************************************
    next_st.port_valid = 1'b0;
    next_st.port_sync = 1'b0;
    next_st.trace_ready = 1'b0;
    case (st.state)
      tpfmt_pkg::TPFMT_IDLE: begin
        if (st.fmt_enable && !st.stopped) begin
          next_st.state = tpfmt_pkg::TPFMT_SYNC;
        end
      end
      tpfmt_pkg::TPFMT_PATTERN: begin
        next_st.trace_ready = 1'b1;
        next_st.port_valid = 1'b1;
        next_st.port_data = `TPFMT_PATTERN_WORD;
        if (!st.pattern_enable) begin
          next_st.state = tpfmt_pkg::TPFMT_IDLE;
        end else if (st.timed_enable) begin
          if (st.pattern_left == 16'h0) begin
            next_st.pattern_enable = 1'b0;
            events[`TPFMT_IRQ_PATTERN_DONE] = 1'b1;
            next_st.state = st.fmt_enable ? tpfmt_pkg::TPFMT_SYNC : tpfmt_pkg::TPFMT_IDLE;
          end else begin
            next_st.pattern_left = st.pattern_left - 16'h1;
          end
        end
      end
      tpfmt_pkg::TPFMT_SYNC: begin
        next_st.port_valid = 1'b1;
        next_st.port_sync = 1'b1;
        next_st.port_data = `TPFMT_SYNC_WORD;
        next_st.frame_count = 12'h0;
        next_st.word_in_frame = 2'h0;
        events[`TPFMT_IRQ_SYNC] = 1'b1;
        next_st.state = tpfmt_pkg::TPFMT_FORMAT;
      end
      tpfmt_pkg::TPFMT_FORMAT: begin
        // normal mode passes only valid words; continuous pads idle cycles
        next_st.trace_ready = 1'b1;
        if (trace_valid && st.trace_ready) begin
          next_st.port_valid = 1'b1;
          next_st.port_data = trace_data;
        end else if (st.continuous) begin
          next_st.port_valid = 1'b1;
          next_st.port_data = 32'h0;
        end
        if (next_st.port_valid) begin
          next_st.word_in_frame = st.word_in_frame + 2'h1;
          if (st.word_in_frame == `TPFMT_FRAME_LAST) begin
            next_st.frame_count = st.frame_count + 12'h1;
            if (st.frame_count + 12'h1 >= st.sync_period && st.sync_period != 12'h0) begin
              next_st.state = tpfmt_pkg::TPFMT_SYNC;
            end
          end
        end
        if (st.manual_flush && st.stop_on_flush) begin
          next_st.trace_ready = 1'b0;
          next_st.manual_flush = 1'b0;
          next_st.fmt_enable = 1'b0;
          next_st.stopped = 1'b1;
          events[`TPFMT_IRQ_STOPPED] = 1'b1;
          next_st.state = tpfmt_pkg::TPFMT_IDLE;
        end else if (!st.fmt_enable) begin
          next_st.state = tpfmt_pkg::TPFMT_IDLE;
        end
      end
      default: begin
        next_st.state = tpfmt_pkg::TPFMT_IDLE;
      end
    endcase
    if (st.state != tpfmt_pkg::TPFMT_FORMAT && st.manual_flush && st.stop_on_flush) begin
      next_st.manual_flush = 1'b0;
      next_st.fmt_enable = 1'b0;
      next_st.stopped = 1'b1;
      events[`TPFMT_IRQ_STOPPED] = 1'b1;
    end
    // Ready only in the format and pattern states; words taken in the pattern state are discarded
    if (next_st.state != tpfmt_pkg::TPFMT_FORMAT && next_st.state != tpfmt_pkg::TPFMT_PATTERN) begin
      next_st.trace_ready = 1'b0;
    end
    // Set wins over a same-cycle clear
    next_st.irq_status = next_st.irq_status | events;
    next_st.irq = |(next_st.irq_status & st.irq_mask);
  end

  // ****************************************************
  // State register
  // ****************************************************
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      st <= '0;
      st.sync_period <= `TPFMT_SYNC_DEFAULT;
      st.state <= tpfmt_pkg::TPFMT_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign s_axi_awready = !st.aw_held;
  assign s_axi_wready = !st.w_held;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign trace_ready = st.trace_ready;
  assign port_data = st.port_data;
  assign port_valid = st.port_valid;
  assign port_sync = st.port_sync;
  assign irq = st.irq;

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  AST_TIMED_END: assert property (
    st.state == tpfmt_pkg::TPFMT_PATTERN && st.pattern_enable && st.timed_enable && st.pattern_left == 16'h0
    |=> !st.pattern_enable) else $error("timed pattern did not end");
  AST_SYNC_AFTER_PATTERN: assert property (
    st.state == tpfmt_pkg::TPFMT_PATTERN && st.pattern_enable && st.timed_enable && st.pattern_left == 16'h0
    && st.fmt_enable |=> ##1 port_sync) else $error("no sync after pattern");
  AST_PERIODIC_SYNC: assert property (
    $rose(port_sync) |-> port_data == `TPFMT_SYNC_WORD && port_valid) else $error("sync word wrong");
  AST_NORMAL_GAPS: assert property (
    st.state == tpfmt_pkg::TPFMT_FORMAT && !st.continuous && !(trace_valid && st.trace_ready)
    && !st.manual_flush |=> !port_valid) else $error("padding in normal mode");
  AST_ENABLE_STARTS: assert property (
    st.state == tpfmt_pkg::TPFMT_IDLE && st.fmt_enable && !st.stopped && !st.manual_flush
    |=> st.state == tpfmt_pkg::TPFMT_SYNC) else $error("enable did not start formatter");
  AST_PATTERN_OUT: assert property (
    st.state == tpfmt_pkg::TPFMT_PATTERN |=> port_data == `TPFMT_PATTERN_WORD) else $error("pattern word wrong");
  AST_DISCARD: assert property (
    st.state == tpfmt_pkg::TPFMT_PATTERN |=> trace_ready && port_data != trace_data || port_data == `TPFMT_PATTERN_WORD)
    else $error("trace leaked in pattern");
  AST_FLUSH_STOPS: assert property (
    st.manual_flush && st.stop_on_flush |=> st.stopped && !st.fmt_enable) else $error("flush did not stop");
  AST_RESTART_SYNC: assert property (
    st.stopped ##1 !st.stopped |=> port_sync) else $error("no sync on restart");
  AST_STATUS_READ: assert property (
    rd_fire && s_axi_araddr == `TPFMT_OFS_FLUSH_STATUS |=> s_axi_rdata[`TPFMT_FS_STOPPED] == $past(st.stopped))
    else $error("stopped flag read wrong");
  AST_RESET_CLEARS: assert property (@(posedge clock) disable iff (1'b0)
    !reset_n |=> !st.stopped && !st.pattern_enable && !st.manual_flush && !st.stop_on_flush)
    else $error("reset did not clear");
  AST_READY_OFF: assert property (
    st.state == tpfmt_pkg::TPFMT_SYNC || st.state == tpfmt_pkg::TPFMT_IDLE |-> !trace_ready)
    else $error("ready without taking");
  AST_IRQ_LEVEL: assert property (
    ##1 irq == $past(|(next_st.irq_status & st.irq_mask))) else $error("irq mismatch");
  COV_TIMED_DONE: cover property (st.irq_status[`TPFMT_IRQ_PATTERN_DONE] ##[1:20] port_sync);
  COV_STOPPED: cover property ($rose(st.stopped));
  COV_RESTART: cover property (st.stopped ##1 !st.stopped ##1 port_sync);
  COV_PERIODIC: cover property (st.state == tpfmt_pkg::TPFMT_FORMAT ##1 st.state == tpfmt_pkg::TPFMT_SYNC);
endmodule : tpfmt_unit
`default_nettype wire

/* File: trace_port_pattern_formatter_tb_top.sv */
// Testbench of the trace port formatter
`timescale 1ns/1ps
`default_nettype none
`include "tpfmt_regs.svh"
module trace_port_pattern_formatter_tb_top;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, trace_data = 32'h0, port_data, rd;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic trace_valid = 1'b0, trace_ready, port_valid, port_sync, irq, clear = 1'b0;
  logic [15:0] n_pat, n_sync, max_run;
  logic first_sync, pat_then_sync, saw_marker;
  int miscompares = 0, n_checks = 0, i;
  tpfmt_unit DUT (.clock(clock), .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .trace_data(trace_data), .trace_valid(trace_valid), .trace_ready(trace_ready), .port_data(port_data),
    .port_valid(port_valid), .port_sync(port_sync), .irq(irq));
  tpfmt_analyzer PTN (.clock(clock), .reset_n(reset_n), .clear(clear), .port_data(port_data),
    .port_valid(port_valid), .port_sync(port_sync), .n_pat(n_pat), .n_sync(n_sync), .max_run(max_run),
    .first_sync(first_sync), .pat_then_sync(pat_then_sync), .saw_marker(saw_marker));
  initial begin
    forever #12.5 clock = ~clock;
  end
  // ****************************************************
  // Tasks
  // ****************************************************
  task wrap_up;
    $display("Checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up
  task tmo;
    miscompares++;
    $display("Error at %0t: wait ran out", $time);
    wrap_up();
  endtask : tmo
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok;
    int k;
    @(posedge clock);
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge clock);
      if (aw_ok && w_ok && s_axi_bvalid === 1'b1) break;
      if (s_axi_awvalid && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    if (k == 64) tmo();
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_write
  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge clock);
      if (s_axi_rvalid === 1'b1) break;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    if (k == 64) tmo();
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_read
  // Source holds each word until the unit takes it
  task automatic send(input int n, input logic [31:0] base);
    int k, j;
    @(posedge clock);
    for (k = 0; k < n; k++) begin
      trace_valid <= 1'b1;
      trace_data <= base + k;
      for (j = 0; j < 64; j++) begin
        @(posedge clock);
        if (trace_ready === 1'b1) break;
      end
      if (j == 64) tmo();
    end
    trace_valid <= 1'b0;
  endtask : send
  task automatic wait_cycles(input int n);
    repeat (n) @(posedge clock);
  endtask : wait_cycles
  // ****************************************************
  // Sequence
  // ****************************************************
  initial begin
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    axi_read(`TPFMT_OFS_FLUSH_CONTROL, rd, rsp);
    chk(rd, 32'h0);
    axi_read(`TPFMT_OFS_FLUSH_STATUS, rd, rsp);
    chk(rd, 32'h0);
    axi_read(`TPFMT_OFS_PATTERN_MODE, rd, rsp);
    chk(rd, 32'h0);
    axi_read(`TPFMT_OFS_SYNC_COUNTER, rd, rsp);
    chk(rd, 32'h40);
    axi_read(12'h040, rd, rsp);
    chk({30'h0, rsp}, 32'h2);
    axi_write(`TPFMT_OFS_SYNC_COUNTER, 32'h0, rsp);
    axi_write(`TPFMT_OFS_IRQ_MASK, 32'h1, rsp);
    axi_write(`TPFMT_OFS_PATTERN_COUNT, 32'h14, rsp);
    axi_write(`TPFMT_OFS_FLUSH_CONTROL, 32'h1, rsp);
    axi_write(`TPFMT_OFS_PATTERN_MODE, 32'h3, rsp);
    send(4, 32'h0bad0bad);
    for (i = 0; i < 300 && irq !== 1'b1; i++) @(posedge clock);
    if (i == 300) tmo();
    wait_cycles(4);
    chk(n_pat, 16'h15);
    chk({31'h0, pat_then_sync}, 32'h1);
    axi_read(`TPFMT_OFS_IRQ_STATUS, rd, rsp);
    chk(rd & 32'h1, 32'h1);
    axi_write(`TPFMT_OFS_IRQ_STATUS, 32'h7, rsp);
    wait_cycles(2);
    chk({31'h0, irq}, 32'h0);
    send(8, 32'h100);
    wait_cycles(4);
    chk({31'h0, saw_marker}, 32'h0);
    clear <= 1'b1;
    axi_write(`TPFMT_OFS_SYNC_COUNTER, 32'h2, rsp);
    clear <= 1'b0;
    send(40, 32'h200);
    wait_cycles(20);
    chk({31'h0, max_run <= 16'h8}, 32'h1);
    chk({31'h0, n_sync >= 16'h4}, 32'h1);
    axi_write(`TPFMT_OFS_IRQ_MASK, 32'h0, rsp);
    axi_write(`TPFMT_OFS_FLUSH_CONTROL, 32'h1041, rsp);
    for (i = 0; i < 20; i++) begin
      axi_read(`TPFMT_OFS_FLUSH_STATUS, rd, rsp);
      if (rd[`TPFMT_FS_STOPPED] === 1'b1) break;
    end
    if (i == 20) tmo();
    axi_read(`TPFMT_OFS_FLUSH_CONTROL, rd, rsp);
    chk(rd, 32'h1000);
    chk({31'h0, irq}, 32'h0);
    axi_write(`TPFMT_OFS_IRQ_MASK, 32'h2, rsp);
    wait_cycles(2);
    chk({31'h0, irq}, 32'h1);
    axi_write(`TPFMT_OFS_IRQ_STATUS, 32'h2, rsp);
    axi_write(`TPFMT_OFS_IRQ_MASK, 32'h0, rsp);
    clear <= 1'b1;
    axi_write(`TPFMT_OFS_FLUSH_CONTROL, 32'h1, rsp);
    clear <= 1'b0;
    axi_read(`TPFMT_OFS_FLUSH_STATUS, rd, rsp);
    chk(rd & 32'h2, 32'h0);
    send(4, 32'h300);
    wait_cycles(8);
    chk({31'h0, first_sync}, 32'h1);
    wrap_up();
  end
endmodule : trace_port_pattern_formatter_tb_top
`default_nettype wire
